// >>> shared/tco_pkg.sv
// types of the timer extension block
package tco_pkg;

	typedef enum logic [2:0] {
		TCO_MODE_FROZEN = 3'h0,
		TCO_MODE_ACT = 3'h1,
		TCO_MODE_INACT = 3'h2,
		TCO_MODE_TOGGLE = 3'h3,
		TCO_MODE_FLOW = 3'h4,
		TCO_MODE_FHIGH = 3'h5,
		TCO_MODE_PWM1 = 3'h6,
		TCO_MODE_PWM2 = 3'h7
	} tco_omode_e;

	typedef enum logic [2:0] {
		TCO_SLV_OFF = 3'h0,
		TCO_SLV_ENC2 = 3'h1,
		TCO_SLV_ENC1 = 3'h2,
		TCO_SLV_ENC12 = 3'h3,
		TCO_SLV_RESET = 3'h4,
		TCO_SLV_GATED = 3'h5,
		TCO_SLV_TRIG = 3'h6,
		TCO_SLV_EXT1 = 3'h7
	} tco_slave_e;

	typedef enum logic [2:0] {
		TCO_ST_IDLE = 3'b001,
		TCO_ST_RUN = 3'b010,
		TCO_ST_DONE = 3'b100
	} tco_run_e;

	// msb first: fast bit 5, complement bit 4, main bit 3, mode bits 2:0
	typedef struct packed {
		logic fast;
		logic comp_en;
		logic main_en;
		logic [2:0] mode;
	} tco_chan_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} tco_bus_req_s;

	typedef struct packed {
		logic [2:0] output_reference;
		logic [2:0] main_output_enable;
		logic [2:0] complement_output_enable;
		logic switch_irq;
		logic switch_dma;
	} tco_out_s;

	typedef struct packed {
		tco_run_e run_st;
		logic run;
		logic dir;
		logic shot;
		logic preload;
		logic hwswitch;
		logic [2:0] slave_mode;
		logic [2:0] trig_sel;
		logic pol1;
		logic pol2;
		tco_chan_s [2:0] pend;
		tco_chan_s [2:0] act;
		logic [2:0] ref_q;
		logic sw_flag;
		logic trig_flag;
		logic upd_flag;
		logic irq_en;
		logic dma_en;
		logic [15:0] cnt;
		logic [15:0] reload;
		logic [2:0][15:0] cmp;
		logic [2:0] s1a;
		logic [2:0] s2a;
		logic f1;
		logic f2;
		logic trg_prev;
		logic [31:0] rdata;
	} tco_state_s;

endpackage : tco_pkg

// >>> shared/tco_regs.svh
// register offsets, field positions, channel count, counter width and reload reset value for the timer extension block
`ifndef TCO_REGS_SVH
`define TCO_REGS_SVH

`define TCO_ADDR_W 4
`define TCO_OFS_CTRL 4'h0
`define TCO_OFS_SLAVE 4'h1
`define TCO_OFS_CHAN 4'h2
`define TCO_OFS_EVENT 4'h3
`define TCO_OFS_STATUS 4'h4
`define TCO_OFS_INTEN 4'h5
`define TCO_OFS_COUNT 4'h6
`define TCO_OFS_RELOAD 4'h7
`define TCO_OFS_CMP0 4'h8
`define TCO_OFS_ACTIVE 4'h9

// control register bits
`define TCO_CTRL_RUN 0
`define TCO_CTRL_DIR 1
`define TCO_CTRL_SHOT 2
`define TCO_CTRL_PRELOAD 3
`define TCO_CTRL_HWSWITCH 4
// slave register fields
`define TCO_SLV_MODE_LO 0
`define TCO_SLV_SEL_LO 4
`define TCO_SLV_POL1 8
`define TCO_SLV_POL2 9
// event register bits
`define TCO_EVT_UPDATE 0
`define TCO_EVT_SWITCH 1
// status bits
`define TCO_ST_SWITCH 0
`define TCO_ST_TRIG 1
`define TCO_ST_UPDATE 2
// irq/dma enable bits
`define TCO_IE_SWITCH 0
`define TCO_DE_SWITCH 1
// per channel field layout in channel register, 6 bits per channel
`define TCO_CH_STRIDE 6
`define TCO_CH_MODE_LO 0
`define TCO_CH_MAIN_EN 3
`define TCO_CH_COMP_EN 4
`define TCO_CH_FAST 5

`define TCO_NCH 3
`define TCO_CNT_W 16
`define TCO_RELOAD_RST 16'hffff

`endif

// >>> testbench/tco_core_tb.sv
// self-checking testbench of the timer extension block
`timescale 1ns/1ps
`include "tco_regs.svh"

module tco_core_tb
	import tco_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	tco_bus_req_s bus_req = '0;
	logic ext_trigger = 1'b0;
	logic [31:0] bus_rdata;
	logic enc_one;
	logic enc_two;
	tco_out_s chan_out;
	logic [15:0] counter_value;
	logic count_dir;
	int mismatches = 0;
	int total_checks = 0;

	always #2.5 clock = ~clock;

	tco_core i_dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.enc_in_one(enc_one), .enc_in_two(enc_two), .ext_trigger(ext_trigger),
		.chan_out(chan_out), .counter_value(counter_value), .count_dir(count_dir));

	tco_enc_model i_enc (.clock(clock), .line_one(enc_one), .line_two(enc_two));

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clock);
		bus_req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clock);
		bus_req.rd <= 1'b0;
		@(negedge clock);
		d = bus_rdata;
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	// preloaded channel setup switched by software, then by trigger edge
	task automatic commute();
		logic [31:0] d;
		wr(`TCO_OFS_INTEN, 32'h3);
		wr(`TCO_OFS_CTRL, 32'h8);
		wr(`TCO_OFS_CHAN, 32'h39f);
		repeat (3) @(negedge clock);
		chk(32'(chan_out.main_output_enable), 32'h0);
		chk(32'(chan_out.switch_irq), 32'h0);
		wr(`TCO_OFS_EVENT, 32'h2);
		repeat (3) @(negedge clock);
		chk(32'(chan_out.main_output_enable), 32'h3);
		chk(32'(chan_out.complement_output_enable), 32'h1);
		chk(32'({chan_out.switch_irq, chan_out.switch_dma}), 32'h3);
		rd(`TCO_OFS_STATUS, d);
		chk(d & 32'h1, 32'h1);
		wr(`TCO_OFS_STATUS, 32'h0);
		repeat (2) @(negedge clock);
		chk(32'(chan_out.switch_irq), 32'h0);
		wr(`TCO_OFS_CTRL, 32'h18);
		wr(`TCO_OFS_CHAN, 32'h16000);
		repeat (3) @(negedge clock);
		chk(32'(chan_out.main_output_enable), 32'h3);
		@(posedge clock);
		ext_trigger <= 1'b1;
		repeat (4) @(negedge clock);
		chk(32'(chan_out.main_output_enable), 32'h0);
		chk(32'(chan_out.complement_output_enable), 32'h4);
		chk(32'(chan_out.switch_irq), 32'h1);
		@(posedge clock);
		ext_trigger <= 1'b0;
		wr(`TCO_OFS_CTRL, 32'h0);
	endtask : commute

	// one triggered pulse; width < 0 skips the width check
	task automatic shot(input logic [31:0] chan, input logic early, input int width);
		logic [31:0] d;
		int hi;
		int k;
		hi = 0;
		k = 0;
		wr(`TCO_OFS_CHAN, chan);
		i_enc.set_two(1'b1);
		while (counter_value !== 16'h1 && k < 20) begin
			@(negedge clock);
			k++;
		end
		if (k == 20) begin
			mismatches++;
			summarize();
		end
		chk(32'(chan_out.output_reference[0]), 32'(early));
		repeat (40) begin
			@(negedge clock);
			if (chan_out.output_reference[0] === 1'b1) hi++;
		end
		if (width >= 0) chk(hi, width);
		rd(`TCO_OFS_CTRL, d);
		chk(d & 32'h1, 32'h0);
		chk(32'(counter_value), 32'h0);
		rd(`TCO_OFS_STATUS, d);
		chk(d & 32'h2, 32'h2);
		i_enc.set_two(1'b0);
		i_enc.settle();
	endtask : shot

	// encoder counting with wrap at reload 5, then two double changes
	task automatic enc(input logic [31:0] slv, input logic [15:0] fwd, input logic [15:0] bck, input logic pol);
		wr(`TCO_OFS_CTRL, 32'h0);
		wr(`TCO_OFS_SLAVE, slv);
		wr(`TCO_OFS_RELOAD, 32'h5);
		wr(`TCO_OFS_EVENT, 32'h1);
		wr(`TCO_OFS_CTRL, 32'h1);
		repeat (4) i_enc.step(1'b0);
		chk(32'(counter_value), 32'(fwd));
		chk(32'(count_dir), 32'(pol));
		repeat (8) i_enc.step(1'b1);
		chk(32'(counter_value), 32'(bck));
		chk(32'(count_dir), {31'h0, ~pol});
		i_enc.both();
		chk(32'(counter_value), 32'(bck));
		i_enc.both();
		chk(32'(counter_value), 32'(bck));
	endtask : enc

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rd(`TCO_OFS_RELOAD, d);
		chk(d, 32'h0000ffff);
		rd(`TCO_OFS_COUNT, d);
		chk(d, 32'h0);
		rd(4'hf, d);
		chk(d, 32'h0);
		commute();
		// pulse setup: count 0 < compare 4 <= reload 10
		wr(`TCO_OFS_RELOAD, 32'ha);
		wr(`TCO_OFS_CMP0, 32'h4);
		wr(`TCO_OFS_SLAVE, 32'h66);
		wr(`TCO_OFS_CTRL, 32'h4);
		wr(`TCO_OFS_EVENT, 32'h1);
		shot(32'h0f, 1'b0, 6);
		shot(32'h2f, 1'b1, -1);
		shot(32'h21, 1'b0, -1);
		enc(32'h003, 16'h4, 16'h2, 1'b0);
		enc(32'h002, 16'h2, 16'h4, 1'b0);
		enc(32'h001, 16'h2, 16'h4, 1'b0);
		enc(32'h103, 16'h2, 16'h4, 1'b1);
		summarize();
	end

endmodule : tco_core_tb

// >>> testbench/tco_enc_model.sv
// quadrature encoder and trigger line model driving the two encoder pins
`timescale 1ns/1ps

module tco_enc_model (
	// clock
	input wire logic clock,
	// encoder lines
	output logic line_one,
	output logic line_two
);
	logic [1:0] ph_q;

	initial begin
		ph_q = 2'h0;
		line_one = 1'b0;
		line_two = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// let the pin synchroniser and counter catch up
	task automatic settle();
		repeat (8) @(posedge clock);
	endtask : settle

	// one gray step, the lines never move together
	task automatic step(input logic back);
		@(posedge clock);
		ph_q = back ? ph_q - 2'h1 : ph_q + 2'h1;
		line_one <= ph_q[1] ^ ph_q[0];
		line_two <= ph_q[1];
		settle();
	endtask : step

	// faulty sensor: both lines flip in one cycle
	task automatic both();
		@(posedge clock);
		line_one <= ~line_one;
		line_two <= ~line_two;
		settle();
	endtask : both

	// input two used as trigger stimulus, no settling
	task automatic set_two(input logic v);
		@(posedge clock);
		line_two <= v;
	endtask : set_two

endmodule : tco_enc_model

// >>> verilog/tco_core.sv
// commutation, single-shot and quadrature encoder logic of a timer channel group
//
// Operation
// (R01) mode and enables preloaded, copied to all channels together at phase switch
// (R02) phase switch from software event bit or trigger input rising edge
// (R03) phase switch sets flag; irq and dma requests when enabled
// (R04) single-shot clears run bit at next update event
// (R05) software sets compare away from start count before trigger
// (R06) single-shot delay equals compare, width equals reload minus compare
// (R07) trigger slave mode 110: trigger edge sets run bit
// (R08) trigger select 110 routes polarity-selected input two as trigger
// (R09) output mode 111 is pwm mode 2
// (R10) fast bit forces compare-match level on trigger stimulus
// (R11) fast bit acts only in pwm mode 1 or 2
// (R12) slave codes 001, 010, 011 select encoder counting inputs
// (R13) polarity bit inverts encoder input; 0 leaves it plain
// (R14) encoder counts valid transitions while run bit set
// (R15) input one edges: rise counts down if two high, fall opposite
// (R16) input two edges: rise counts up if one high; both mode combines
// (R17) direction flag updated on every transition of either input
// (R18) encoder counts between 0 and reload, wrapping both ways
// (R19) compare and trigger functions keep working in encoder mode
// (R20) software never combines encoder mode with external clock mode 2
// (R21) simultaneous change on both inputs is ignored
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "tco_regs.svh"

module tco_core
	import tco_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire tco_bus_req_s bus_req,
	output logic [31:0] bus_rdata,
	// pins
	input wire logic enc_in_one,
	input wire logic enc_in_two,
	input wire logic ext_trigger,
	// outputs
	output tco_out_s chan_out,
	output logic [15:0] counter_value,
	output logic count_dir
);

	tco_state_s s_q;
	tco_state_s s_d;

	////////////////////////////////////////////////////////////////////////////////
	// combinational helpers

	logic in1_raw;
	logic in2_raw;
	logic filtered_input_one;
	logic filtered_input_two;
	logic ch1;
	logic ch2;
	logic trigger_input;
	logic trig_edge;
	logic encoder_on;
	logic wr_event;
	logic sw_event;
	logic upd_evt;
	logic cnt_step;
	logic cnt_dn;
	logic enc_step;
	logic enc_dn;
	logic trig_start;
	logic [15:0] cnt_next;
	logic [31:0] wd;

	assign wd = bus_req.wdata;
	// settled synchroniser levels: second and third stage agree
	assign in1_raw = (s_q.s1a[1] == s_q.s1a[2]) ? s_q.s1a[2] : s_q.f1 ^ s_q.pol1;
	assign in2_raw = (s_q.s2a[1] == s_q.s2a[2]) ? s_q.s2a[2] : s_q.f2 ^ s_q.pol2;
	assign filtered_input_one = in1_raw ^ s_q.pol1; // R13
	assign filtered_input_two = in2_raw ^ s_q.pol2; // R13
	assign ch1 = filtered_input_one != s_q.f1;
	assign ch2 = filtered_input_two != s_q.f2;

	always_comb begin
		case (s_q.trig_sel)
			3'h6: trigger_input = filtered_input_two; // R08
			3'h5: trigger_input = filtered_input_one;
			default: trigger_input = ext_trigger;
		endcase
	end
	assign trig_edge = trigger_input & ~s_q.trg_prev;

	assign encoder_on = (s_q.slave_mode == TCO_SLV_ENC1) || (s_q.slave_mode == TCO_SLV_ENC2)
		|| (s_q.slave_mode == TCO_SLV_ENC12); // R12
	assign wr_event = bus_req.wr && (bus_req.addr == `TCO_OFS_EVENT);
	assign sw_event = (wr_event && wd[`TCO_EVT_SWITCH]) || (s_q.hwswitch && trig_edge); // R02

	// encoder decode, one input change at a time
	always_comb begin
		enc_step = 1'b0;
		enc_dn = s_q.dir;
		if (ch1 && !ch2) begin // R21
			enc_dn = filtered_input_one ? filtered_input_two : ~filtered_input_two; // R15 R17
			enc_step = (s_q.slave_mode == TCO_SLV_ENC1) || (s_q.slave_mode == TCO_SLV_ENC12);
		end else if (ch2 && !ch1) begin
			enc_dn = filtered_input_two ? ~filtered_input_one : filtered_input_one; // R16 R17
			enc_step = (s_q.slave_mode == TCO_SLV_ENC2) || (s_q.slave_mode == TCO_SLV_ENC12);
		end
	end

	assign trig_start = (s_q.slave_mode == TCO_SLV_TRIG) && trig_edge && !s_q.run; // R07
	assign cnt_step = s_q.run && (encoder_on ? (enc_step && encoder_on) : 1'b1); // R14
	assign cnt_dn = encoder_on ? enc_dn : s_q.dir;
	// R18 wrap at both ends
	always_comb begin
		if (cnt_dn)
			cnt_next = (s_q.cnt == 16'h0000) ? s_q.reload : s_q.cnt - 16'h0001;
		else
			cnt_next = (s_q.cnt >= s_q.reload) ? 16'h0000 : s_q.cnt + 16'h0001;
	end
	assign upd_evt = cnt_step && (cnt_dn ? (s_q.cnt == 16'h0000) : (s_q.cnt >= s_q.reload));

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		s_d.s1a = {s_q.s1a[1:0], enc_in_one};
		s_d.s2a = {s_q.s2a[1:0], enc_in_two};
		s_d.f1 = filtered_input_one;
		s_d.f2 = filtered_input_two;
		s_d.trg_prev = trigger_input;
		s_d.rdata = 32'h0000_0000;
		if (!(ch1 && ch2) && encoder_on && (ch1 || ch2))
			s_d.dir = enc_dn; // R17

		// counter
		if (cnt_step)
			s_d.cnt = cnt_next; // R19
		if (upd_evt) begin
			s_d.upd_flag = 1'b1;
			if (s_q.shot) begin
				s_d.run = 1'b0; // R04
				s_d.run_st = TCO_ST_DONE;
			end
		end
		if (trig_start) begin
			s_d.run = 1'b1; // R07
			s_d.run_st = TCO_ST_RUN;
			s_d.trig_flag = 1'b1;
		end

		// output references per channel
		for (int i = 0; i < `TCO_NCH; i++) begin
			// a fast channel in pwm mode 1 or 2 holds its forced level for the whole run
			if (s_q.act[i].mode == TCO_MODE_PWM1)
				s_d.ref_q[i] = (s_q.cnt < s_q.cmp[i]) && !(s_q.act[i].fast && s_q.run); // R10 R11
			else if (s_q.act[i].mode == TCO_MODE_PWM2)
				s_d.ref_q[i] = ((s_q.cnt >= s_q.cmp[i]) && !(s_q.shot && s_q.cnt >= s_q.reload))
					|| (s_q.act[i].fast && s_q.run); // R06 R09 R10
			else if (s_q.act[i].mode == TCO_MODE_FLOW)
				s_d.ref_q[i] = 1'b0;
			else if (s_q.act[i].mode == TCO_MODE_FHIGH)
				s_d.ref_q[i] = 1'b1;
			else if (s_q.act[i].mode == TCO_MODE_ACT && s_q.cnt == s_q.cmp[i])
				s_d.ref_q[i] = 1'b1;
			else if (s_q.act[i].mode == TCO_MODE_INACT && s_q.cnt == s_q.cmp[i])
				s_d.ref_q[i] = 1'b0;
			else if (s_q.act[i].mode == TCO_MODE_TOGGLE && s_q.cnt == s_q.cmp[i])
				s_d.ref_q[i] = ~s_q.ref_q[i];
			if (trig_start && s_q.act[i].fast) begin
				if (s_q.act[i].mode == TCO_MODE_PWM1) // R11
					s_d.ref_q[i] = 1'b0; // R10
				else if (s_q.act[i].mode == TCO_MODE_PWM2)
					s_d.ref_q[i] = 1'b1; // R10
			end
		end

		// register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				`TCO_OFS_CTRL: begin
					s_d.run = wd[`TCO_CTRL_RUN];
					s_d.run_st = wd[`TCO_CTRL_RUN] ? TCO_ST_RUN : TCO_ST_IDLE;
					s_d.dir = wd[`TCO_CTRL_DIR];
					s_d.shot = wd[`TCO_CTRL_SHOT];
					s_d.preload = wd[`TCO_CTRL_PRELOAD];
					s_d.hwswitch = wd[`TCO_CTRL_HWSWITCH];
				end
				`TCO_OFS_SLAVE: begin
					s_d.slave_mode = wd[`TCO_SLV_MODE_LO +: 3];
					s_d.trig_sel = wd[`TCO_SLV_SEL_LO +: 3];
					s_d.pol1 = wd[`TCO_SLV_POL1];
					s_d.pol2 = wd[`TCO_SLV_POL2];
				end
				`TCO_OFS_CHAN: begin
					for (int i = 0; i < `TCO_NCH; i++) begin
						s_d.pend[i] = wd[i*`TCO_CH_STRIDE +: `TCO_CH_STRIDE];
						if (!s_q.preload)
							s_d.act[i] = wd[i*`TCO_CH_STRIDE +: `TCO_CH_STRIDE];
					end
				end
				`TCO_OFS_EVENT: begin
					if (wd[`TCO_EVT_UPDATE])
						s_d.cnt = s_q.dir ? s_q.reload : 16'h0000;
				end
				`TCO_OFS_STATUS: begin
					// write zero clears; a same-cycle hardware set wins below
					s_d.sw_flag = s_q.sw_flag & wd[`TCO_ST_SWITCH];
					s_d.trig_flag = s_q.trig_flag & wd[`TCO_ST_TRIG];
					s_d.upd_flag = s_q.upd_flag & wd[`TCO_ST_UPDATE];
				end
				`TCO_OFS_INTEN: begin
					s_d.irq_en = wd[`TCO_IE_SWITCH];
					s_d.dma_en = wd[`TCO_DE_SWITCH];
				end
				`TCO_OFS_COUNT: s_d.cnt = wd[15:0];
				`TCO_OFS_RELOAD: s_d.reload = wd[15:0];
				default: begin
					if (bus_req.addr >= `TCO_OFS_CMP0 && bus_req.addr < `TCO_OFS_ACTIVE)
						s_d.cmp[0] = wd[15:0];
				end
			endcase
		end
		if (bus_req.wr && bus_req.addr == `TCO_OFS_ACTIVE) begin
			s_d.cmp[1] = wd[15:0];
			s_d.cmp[2] = wd[31:16];
		end

		// phase switch event
		if (sw_event) begin
			s_d.sw_flag = 1'b1; // R03
			if (s_q.preload)
				s_d.act = s_q.pend; // R01
		end
		if (trig_start)
			s_d.trig_flag = 1'b1;
		if (upd_evt)
			s_d.upd_flag = 1'b1;

		// register reads
		if (bus_req.rd) begin
			case (bus_req.addr)
				`TCO_OFS_CTRL: s_d.rdata = {27'h0, s_q.hwswitch, s_q.preload, s_q.shot, s_q.dir, s_q.run};
				`TCO_OFS_SLAVE: s_d.rdata = {22'h0, s_q.pol2, s_q.pol1, 1'b0, s_q.trig_sel, 1'b0, s_q.slave_mode};
				`TCO_OFS_CHAN: s_d.rdata = {14'h0, s_q.pend};
				`TCO_OFS_STATUS: s_d.rdata = {29'h0, s_q.upd_flag, s_q.trig_flag, s_q.sw_flag};
				`TCO_OFS_INTEN: s_d.rdata = {30'h0, s_q.dma_en, s_q.irq_en};
				`TCO_OFS_COUNT: s_d.rdata = {16'h0, s_q.cnt};
				`TCO_OFS_RELOAD: s_d.rdata = {16'h0, s_q.reload};
				`TCO_OFS_CMP0: s_d.rdata = {16'h0, s_q.cmp[0]};
				`TCO_OFS_ACTIVE: s_d.rdata = {s_q.cmp[2], s_q.cmp[1]};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.run_st <= TCO_ST_IDLE;
			s_q.reload <= `TCO_RELOAD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign bus_rdata = s_q.rdata;
	assign counter_value = s_q.cnt;
	assign count_dir = s_q.dir;

	generate
		for (genvar g = 0; g < `TCO_NCH; g++) begin : g_out
			assign chan_out.output_reference[g] = s_q.ref_q[g];
			assign chan_out.main_output_enable[g] = s_q.act[g].main_en;
			assign chan_out.complement_output_enable[g] = s_q.act[g].comp_en;
		end
	endgenerate
	assign chan_out.switch_irq = s_q.sw_flag & s_q.irq_en; // R03
	assign chan_out.switch_dma = s_q.sw_flag & s_q.dma_en; // R03

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_shot_stop: assert property (@(posedge clock) disable iff (!rst_n)
		(upd_evt && s_q.shot && !bus_req.wr) |=> !s_q.run) else $error("single shot did not stop"); // R04
	chk_trig_start: assert property (@(posedge clock) disable iff (!rst_n)
		(trig_start && !bus_req.wr) |=> s_q.run && s_q.trig_flag) else $error("trigger did not start"); // R07
	chk_switch_copy: assert property (@(posedge clock) disable iff (!rst_n)
		(sw_event && s_q.preload && !bus_req.wr) |=> s_q.act == $past(s_q.pend)) else $error("preload not copied"); // R01
	chk_switch_flag: assert property (@(posedge clock) disable iff (!rst_n)
		sw_event |=> s_q.sw_flag) else $error("switch flag missing"); // R03
	chk_irq_gate: assert property (@(posedge clock) disable iff (!rst_n)
		chan_out.switch_irq |-> s_q.irq_en) else $error("irq without enable"); // R03
	chk_dual_change: assert property (@(posedge clock) disable iff (!rst_n)
		(ch1 && ch2 && !bus_req.wr) |=> s_q.cnt == $past(s_q.cnt)) else $error("dual change counted"); // R21
	chk_enc_range: assert property (@(posedge clock) disable iff (!rst_n)
		(encoder_on && s_q.cnt <= s_q.reload && !bus_req.wr && !$past(bus_req.wr)) |=> s_q.cnt <= s_q.reload)
		else $error("encoder out of range"); // R18
	chk_enc_idle: assert property (@(posedge clock) disable iff (!rst_n)
		(encoder_on && !s_q.run && !bus_req.wr) |=> $stable(s_q.cnt)) else $error("encoder counted while stopped"); // R14
	chk_fast_pwm2: assert property (@(posedge clock) disable iff (!rst_n)
		(trig_start && s_q.act[0].fast && s_q.act[0].mode == TCO_MODE_PWM2 && !bus_req.wr) |=> s_q.ref_q[0])
		else $error("fast output not forced"); // R10

endmodule : tco_core
